// File: rtl/txrs_bank.sv
/*
 * txrs_bank: transmit stabilization / interframe timing, encryption bypass
 * and receive security status, as an APB slave with a level interrupt.
 * Assumes pclk at 25 MHz, events from same-clock logic, and the supply
 * level and frame done inputs arriving asynchronously from analog/pins.
 */
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
module txrs_bank #(
    parameter int SYMBOL_CYCLES = txrs_pkg::SYMBOL_CYCLES,
    parameter int THRESH_W = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tx_request,
    input wire logic tx_secure,
    input wire logic tx_frame_done,
    input wire txrs_pkg::txrs_rx_event_s rx_event,
    input wire logic supply_below_threshold,
    output txrs_pkg::txrs_tx_cmd_s tx_cmd,
    output logic tx_busy,
    output logic irq,
    output logic battery_monitor_enable,
    output logic [THRESH_W-1:0] battery_threshold
);

    if (SYMBOL_CYCLES < 2 || SYMBOL_CYCLES > 65535 || THRESH_W != 4) begin : g_bad_params
        $error("txrs_bank: unsupported parameter values");
    end

    // one register decoder, used by both the write and the read path
    function automatic logic is_reg(input logic [11:0] a, input logic [11:0] r);
        return a == r;
    endfunction : is_reg

    logic encrypt_disable;
    logic [3:0] vco_settle_symbols;
    logic [3:0] min_short_gap_symbols;
    logic upper_layer_mic_error;
    logic battery_low_flag;
    logic decrypt_error_flag;
    logic [txrs_pkg::IRQ_W-1:0] irq_status;
    logic [txrs_pkg::IRQ_W-1:0] irq_mask;
    logic [txrs_pkg::IRQ_W-1:0] irq_events;
    logic bat_meta;
    logic bat_sync;
    logic bat_sync_q;
    logic done_meta;
    logic done_sync;
    logic done_sync_q;
    logic frame_done_pulse;
    logic [15:0] sym_div;
    logic sym_tick;
    logic [3:0] sym_left;
    txrs_pkg::txrs_tx_state_e state;
    logic pending;
    logic pending_secure;

    // accesses complete with zero wait states
    wire logic wr_en = psel && penable && pwrite && pstrb[0];
    wire logic known = is_reg(paddr, txrs_pkg::SECURITY_CONTROL_ONE_ADDR)
        || is_reg(paddr, txrs_pkg::TX_STABILIZATION_ADDR) || is_reg(paddr, txrs_pkg::RX_MAC_STATUS_ADDR)
        || is_reg(paddr, txrs_pkg::MONITOR_CONFIG_ADDR) || is_reg(paddr, txrs_pkg::IRQ_STATUS_ADDR)
        || is_reg(paddr, txrs_pkg::IRQ_MASK_ADDR) || is_reg(paddr, txrs_pkg::TX_CONTROL_ADDR)
        || is_reg(paddr, txrs_pkg::TX_STATUS_ADDR);

    // asynchronous inputs: two flops before any logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bat_meta <= 1'b0;
            bat_sync <= 1'b0;
            done_meta <= 1'b0;
            done_sync <= 1'b0;
        end else begin
            bat_meta <= supply_below_threshold;
            bat_sync <= bat_meta;
            done_meta <= tx_frame_done;
            done_sync <= done_meta;
        end
    end

    // edge detectors read only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bat_sync_q <= 1'b0;
            done_sync_q <= 1'b0;
        end else begin
            bat_sync_q <= bat_sync;
            done_sync_q <= done_sync;
        end
    end
    assign frame_done_pulse = done_sync && !done_sync_q;

    // security control: only the encryption bypass lives here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            encrypt_disable <= 1'b0;
        end else if (wr_en && is_reg(paddr, txrs_pkg::SECURITY_CONTROL_ONE_ADDR)) begin
            encrypt_disable <= pwdata[txrs_pkg::ENCRYPT_DISABLE_BIT];
        end
    end

    // stabilization register; sum of twelve is left to software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vco_settle_symbols <= txrs_pkg::VCO_SETTLE_RESET;
            min_short_gap_symbols <= txrs_pkg::MIN_GAP_RESET;
        end else if (wr_en && is_reg(paddr, txrs_pkg::TX_STABILIZATION_ADDR)) begin
            vco_settle_symbols <= pwdata[txrs_pkg::VCO_SETTLE_LSB +: 4];
            min_short_gap_symbols <= pwdata[txrs_pkg::MIN_GAP_LSB +: 4];
        end
    end

    // monitor config is driven out to the analog monitor
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            battery_monitor_enable <= 1'b0;
            battery_threshold <= '0;
        end else if (wr_en && is_reg(paddr, txrs_pkg::MONITOR_CONFIG_ADDR)) begin
            battery_monitor_enable <= pwdata[txrs_pkg::MON_ENABLE_BIT];
            battery_threshold <= pwdata[txrs_pkg::MON_THRESH_LSB +: THRESH_W];
        end
    end

    // mic error sticky, write-one clears; a new event wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upper_layer_mic_error <= 1'b0;
        end else if (rx_event.mic_error) begin
            upper_layer_mic_error <= 1'b1;
        end else if (wr_en && is_reg(paddr, txrs_pkg::RX_MAC_STATUS_ADDR)
                     && pwdata[txrs_pkg::MIC_ERR_BIT]) begin
            upper_layer_mic_error <= 1'b0;
        end
    end

    // decrypt status follows the last frame's result, read-only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            decrypt_error_flag <= 1'b0;
        end else if (rx_event.decrypt_error) begin
            decrypt_error_flag <= 1'b1;
        end else if (rx_event.decrypt_ok) begin
            decrypt_error_flag <= 1'b0;
        end
    end

    // battery flag only meaningful while the monitor runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            battery_low_flag <= 1'b0;
        end else begin
            battery_low_flag <= bat_sync && battery_monitor_enable;
        end
    end

    // interrupt events: one cycle each
    always_comb begin
        irq_events = '0;
        irq_events[txrs_pkg::IRQ_MIC] = rx_event.mic_error;
        irq_events[txrs_pkg::IRQ_DECRYPT] = rx_event.decrypt_error;
        irq_events[txrs_pkg::IRQ_BATLOW] = bat_sync && !bat_sync_q && battery_monitor_enable;
        irq_events[txrs_pkg::IRQ_TXDONE] = (state == txrs_pkg::TXRS_GAP) && sym_tick && sym_left == 4'h0;
    end

    // sticky status, write-one clear, set beats clear per bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= '0;
        end else if (wr_en && is_reg(paddr, txrs_pkg::IRQ_STATUS_ADDR)) begin
            irq_status <= (irq_status & ~pwdata[txrs_pkg::IRQ_W-1:0]) | irq_events;
        end else begin
            irq_status <= irq_status | irq_events;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= '0;
        end else if (wr_en && is_reg(paddr, txrs_pkg::IRQ_MASK_ADDR)) begin
            irq_mask <= pwdata[txrs_pkg::IRQ_W-1:0];
        end
    end

    // registered interrupt lags the status by one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // symbol-period enable: free running divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sym_div <= '0;
        end else if (sym_div == 16'(SYMBOL_CYCLES - 1)) begin
            sym_div <= '0;
        end else begin
            sym_div <= sym_div + 16'h0001;
        end
    end
    assign sym_tick = sym_div == 16'(SYMBOL_CYCLES - 1);

    // one request waits while a frame is in flight
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending <= 1'b0;
            pending_secure <= 1'b0;
        end else if (tx_request) begin
            pending <= 1'b1;
            pending_secure <= tx_secure;
        end else if (state == txrs_pkg::TXRS_IDLE && pending) begin
            pending <= 1'b0;
        end
    end

    // settle, send, then hold the short gap before the next frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= txrs_pkg::TXRS_IDLE;
            sym_left <= 4'h0;
            tx_cmd <= '0;
        end else begin
            tx_cmd.start <= 1'b0;
            unique case (state)
                txrs_pkg::TXRS_IDLE: begin
                    if (pending) begin
                        state <= txrs_pkg::TXRS_SETTLE;
                        sym_left <= vco_settle_symbols;
                        // bypass chosen once per frame, not mid-frame
                        tx_cmd.encrypt <= pending_secure && !encrypt_disable;
                    end
                end
                txrs_pkg::TXRS_SETTLE: begin
                    if (sym_left == 4'h0) begin
                        state <= txrs_pkg::TXRS_SEND;
                        tx_cmd.start <= 1'b1;
                    end else if (sym_tick) begin
                        sym_left <= sym_left - 4'h1;
                    end
                end
                txrs_pkg::TXRS_SEND: begin
                    if (frame_done_pulse) begin
                        state <= txrs_pkg::TXRS_GAP;
                        sym_left <= min_short_gap_symbols;
                    end
                end
                txrs_pkg::TXRS_GAP: begin
                    if (sym_tick) begin
                        if (sym_left == 4'h0) begin
                            state <= txrs_pkg::TXRS_IDLE;
                        end else begin
                            sym_left <= sym_left - 4'h1;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_busy <= 1'b0;
        end else begin
            tx_busy <= state != txrs_pkg::TXRS_IDLE;
        end
    end

    // read mux; reserved bits, status bit 7 among them, read zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else begin
            prdata <= '0;
            if (psel && !penable && !pwrite) begin
                if (is_reg(paddr, txrs_pkg::SECURITY_CONTROL_ONE_ADDR)) begin
                    prdata[txrs_pkg::ENCRYPT_DISABLE_BIT] <= encrypt_disable;
                end else if (is_reg(paddr, txrs_pkg::TX_STABILIZATION_ADDR)) begin
                    prdata[7:0] <= {vco_settle_symbols, min_short_gap_symbols};
                end else if (is_reg(paddr, txrs_pkg::RX_MAC_STATUS_ADDR)) begin
                    prdata[txrs_pkg::MIC_ERR_BIT] <= upper_layer_mic_error;
                    prdata[txrs_pkg::BAT_LOW_BIT] <= battery_low_flag;
                    prdata[txrs_pkg::DECRYPT_ERR_BIT] <= decrypt_error_flag;
                end else if (is_reg(paddr, txrs_pkg::MONITOR_CONFIG_ADDR)) begin
                    prdata[txrs_pkg::MON_ENABLE_BIT] <= battery_monitor_enable;
                    prdata[txrs_pkg::MON_THRESH_LSB +: THRESH_W] <= battery_threshold;
                end else if (is_reg(paddr, txrs_pkg::IRQ_STATUS_ADDR)) begin
                    prdata[txrs_pkg::IRQ_W-1:0] <= irq_status;
                end else if (is_reg(paddr, txrs_pkg::IRQ_MASK_ADDR)) begin
                    prdata[txrs_pkg::IRQ_W-1:0] <= irq_mask;
                end else if (is_reg(paddr, txrs_pkg::TX_STATUS_ADDR)) begin
                    prdata[1:0] <= state;
                end
            end
        end
    end

    // pready high in access phase; unmapped addresses error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !known;
        end
    end

    a_settle_reset: assert property (@(posedge pclk) $rose(presetn)
        |-> vco_settle_symbols == txrs_pkg::VCO_SETTLE_RESET && min_short_gap_symbols == txrs_pkg::MIN_GAP_RESET)
        else $error("stabilization fields not at reset values");
    a_encrypt_bypass: assert property (@(posedge pclk) disable iff (!presetn)
        state == txrs_pkg::TXRS_IDLE && pending && encrypt_disable |=> !tx_cmd.encrypt)
        else $error("frame encrypted while bypass set");
    a_settle_load: assert property (@(posedge pclk) disable iff (!presetn)
        state == txrs_pkg::TXRS_IDLE && pending |=> sym_left == $past(vco_settle_symbols))
        else $error("settle count not loaded");
    a_no_early_start: assert property (@(posedge pclk) disable iff (!presetn)
        tx_cmd.start |-> $past(state) == txrs_pkg::TXRS_SETTLE)
        else $error("frame started without settling");
    a_gap_load: assert property (@(posedge pclk) disable iff (!presetn)
        state == txrs_pkg::TXRS_SEND && frame_done_pulse |=> state == txrs_pkg::TXRS_GAP
        && sym_left == $past(min_short_gap_symbols))
        else $error("gap count not loaded");
    a_mic_set: assert property (@(posedge pclk) disable iff (!presetn)
        rx_event.mic_error |=> upper_layer_mic_error)
        else $error("mic error flag not set");
    a_mic_clear: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && is_reg(paddr, txrs_pkg::RX_MAC_STATUS_ADDR) && pwdata[txrs_pkg::MIC_ERR_BIT]
        && !rx_event.mic_error |=> !upper_layer_mic_error)
        else $error("mic error flag not cleared");
    a_battery_flag: assert property (@(posedge pclk) disable iff (!presetn)
        battery_low_flag |-> $past(bat_sync) && $past(battery_monitor_enable))
        else $error("battery flag without low supply");
    a_bit7_zero: assert property (@(posedge pclk) disable iff (!presetn)
        pready && $past(is_reg(paddr, txrs_pkg::RX_MAC_STATUS_ADDR)) |-> prdata[7] == 1'b0)
        else $error("status bit 7 read as one");
    a_decrypt_flag: assert property (@(posedge pclk) disable iff (!presetn)
        rx_event.decrypt_error |=> decrypt_error_flag)
        else $error("decrypt error not flagged");
    c_frame_sent: cover property (@(posedge pclk) disable iff (!presetn) tx_cmd.start);
    c_bypass: cover property (@(posedge pclk) disable iff (!presetn) tx_cmd.start && !tx_cmd.encrypt);
    c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
    c_mic_race: cover property (@(posedge pclk) disable iff (!presetn)
        rx_event.mic_error && wr_en && is_reg(paddr, txrs_pkg::RX_MAC_STATUS_ADDR));
endmodule : txrs_bank

// File: rtl/txrs_pkg.sv
/*
 * txrs_pkg: constants and carriers for the transmit timing / receive
 * security status register bank. Assumes an APB slave with 32-bit data.
 */
package txrs_pkg;
    // register indices; the APB byte address is four times the index
    localparam logic [7:0] SECURITY_CONTROL_ONE_IDX = 8'h2D;
    localparam logic [7:0] TX_STABILIZATION_IDX = 8'h2E;
    localparam logic [7:0] RX_MAC_STATUS_IDX = 8'h30;
    localparam logic [11:0] SECURITY_CONTROL_ONE_ADDR = {2'h0, SECURITY_CONTROL_ONE_IDX, 2'h0};
    localparam logic [11:0] TX_STABILIZATION_ADDR = {2'h0, TX_STABILIZATION_IDX, 2'h0};
    localparam logic [11:0] RX_MAC_STATUS_ADDR = {2'h0, RX_MAC_STATUS_IDX, 2'h0};
    localparam logic [11:0] MONITOR_CONFIG_ADDR = 12'h100;
    localparam logic [11:0] IRQ_STATUS_ADDR = 12'h104;
    localparam logic [11:0] IRQ_MASK_ADDR = 12'h108;
    localparam logic [11:0] TX_CONTROL_ADDR = 12'h10C;
    localparam logic [11:0] TX_STATUS_ADDR = 12'h110;

    // field positions
    localparam int ENCRYPT_DISABLE_BIT = 0;
    localparam int VCO_SETTLE_LSB = 4;
    localparam int MIN_GAP_LSB = 0;
    localparam int MIC_ERR_BIT = 6;
    localparam int BAT_LOW_BIT = 5;
    localparam int DECRYPT_ERR_BIT = 2;
    localparam int MON_ENABLE_BIT = 4;
    localparam int MON_THRESH_LSB = 0;

    // reset values, advised settle and minimum SIFS
    localparam logic [3:0] VCO_SETTLE_RESET = 4'h7;
    localparam logic [3:0] VCO_SETTLE_ADVISED = 4'h9;
    localparam logic [3:0] MIN_GAP_RESET = 4'h5;
    localparam logic [3:0] MIN_SIFS_SYMBOLS = 4'hC;

    // timing: one symbol is 16 us at a 25 MHz clock
    localparam int CLK_MHZ = 25;
    localparam int SYMBOL_US = 16;
    localparam int SYMBOL_CYCLES = SYMBOL_US * CLK_MHZ;

    // interrupt status bits
    localparam int IRQ_MIC = 0;
    localparam int IRQ_DECRYPT = 1;
    localparam int IRQ_BATLOW = 2;
    localparam int IRQ_TXDONE = 3;
    localparam int IRQ_W = 4;

    typedef enum logic [1:0] {
        TXRS_IDLE = 2'b00,
        TXRS_SETTLE = 2'b01,
        TXRS_SEND = 2'b10,
        TXRS_GAP = 2'b11
    } txrs_tx_state_e;

    // what the transmit datapath is told for one frame
    typedef struct packed {
        logic start;
        logic encrypt;
    } txrs_tx_cmd_s;

    // receive security events from the rest of the device
    typedef struct packed {
        logic mic_error;
        logic decrypt_error;
        logic decrypt_ok;
    } txrs_rx_event_s;
endpackage : txrs_pkg

// File: dv/txrs_tx_sink.sv
/*
 * txrs_tx_sink: stand-in for the transmit datapath behind the bank.
 * Assumes tx_cmd comes from the bank on the same pclk.
 */
`timescale 1ns/1ns
module txrs_tx_sink #(
    parameter int DELAY = 5
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire txrs_pkg::txrs_tx_cmd_s tx_cmd,
    output logic tx_frame_done
);
    int cnt;

    // frame airtime: one done pulse DELAY cycles after start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            tx_frame_done <= 1'b0;
        end else if (tx_cmd.start) begin
            cnt <= DELAY;
            tx_frame_done <= 1'b0;
        end else begin
            cnt <= (cnt > 0) ? cnt - 1 : 0;
            tx_frame_done <= (cnt == 1);
        end
    end
endmodule : txrs_tx_sink

// File: dv/test_tx_timing_rx_security_status.sv
/*
 * test_tx_timing_rx_security_status: APB-driven checks of the bank.
 * Assumes the bank answers on APB with zero wait and a short symbol.
 */
`timescale 1ns/1ns
module test_tx_timing_rx_security_status;
    localparam int SYM = 4;
    localparam int D = 5;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready, pslverr, tx_frame_done, tx_busy, irq, battery_monitor_enable;
    logic tx_request = 1'b0;
    logic tx_secure = 1'b0;
    logic supply_below_threshold = 1'b0;
    logic [3:0] battery_threshold;
    txrs_pkg::txrs_rx_event_s rx_event = '0;
    txrs_pkg::txrs_tx_cmd_s tx_cmd;
    logic [31:0] rd;
    logic err;
    int n_errors = 0;
    int cmp_count = 0;
    int n;

    always #20 pclk = ~pclk;

    txrs_bank #(.SYMBOL_CYCLES(SYM), .THRESH_W(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_request(tx_request), .tx_secure(tx_secure),
        .tx_frame_done(tx_frame_done), .rx_event(rx_event), .supply_below_threshold(supply_below_threshold),
        .tx_cmd(tx_cmd), .tx_busy(tx_busy), .irq(irq), .battery_monitor_enable(battery_monitor_enable),
        .battery_threshold(battery_threshold));

    txrs_tx_sink #(.DELAY(D)) sink_u (.pclk(pclk), .presetn(presetn), .tx_cmd(tx_cmd),
        .tx_frame_done(tx_frame_done));

    task automatic print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // a used-up wait ends the run at once
    task automatic bound(input int lim);
        if (n >= lim) begin
            n_errors++;
            $display("[FAIL] wait bound expected done seen hang");
            print_verdict();
        end
    endtask : bound

    // one APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        bound(20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask : rdc

    // one-cycle event pulse on the receive side
    task automatic ev(input logic [2:0] e);
        @(posedge pclk);
        rx_event <= txrs_pkg::txrs_rx_event_s'(e);
        @(posedge pclk);
        rx_event <= '0;
    endtask : ev

    // one secure frame: settle 2 symbols, gap 10 symbols
    task automatic txrun(input logic exp_enc);
        @(posedge pclk);
        tx_request <= 1'b1;
        tx_secure <= 1'b1;
        @(posedge pclk);
        tx_request <= 1'b0;
        n = 1;
        while (tx_cmd.start !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        bound(200);
        chk("settle window", 32'h1, 32'(n >= SYM && n <= 2 * SYM + 6));
        chk("encrypt", {31'h0, exp_enc}, {31'h0, tx_cmd.encrypt});
        n = 0;
        while (tx_busy !== 1'b0 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        bound(200);
        chk("gap window", 32'h1, 32'(n >= D + 9 * SYM && n <= D + 11 * SYM + 8));
    endtask : txrun

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdc("stab reset", txrs_pkg::TX_STABILIZATION_ADDR, 32'h75);
        rdc("status reset", txrs_pkg::RX_MAC_STATUS_ADDR, 32'h0);
        rdc("secctl reset", txrs_pkg::SECURITY_CONTROL_ONE_ADDR, 32'h0);
        apb(1'b0, 12'hFFC, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        $display("test reset done");
        // advised settle first, then a short settle for the frame runs
        apb(1'b1, txrs_pkg::TX_STABILIZATION_ADDR, 32'h93);
        rdc("stab advised", txrs_pkg::TX_STABILIZATION_ADDR, 32'h93);
        apb(1'b1, txrs_pkg::TX_STABILIZATION_ADDR, 32'h2A);
        $display("test timing regs done");
        apb(1'b1, txrs_pkg::IRQ_MASK_ADDR, 32'hF);
        ev(3'b100);
        rdc("mic flag", txrs_pkg::RX_MAC_STATUS_ADDR, 32'h40);
        chk("irq raised", 32'h1, {31'h0, irq});
        apb(1'b1, txrs_pkg::RX_MAC_STATUS_ADDR, 32'h40);
        rdc("mic cleared", txrs_pkg::RX_MAC_STATUS_ADDR, 32'h0);
        apb(1'b1, txrs_pkg::IRQ_STATUS_ADDR, 32'hF);
        repeat (2) @(posedge pclk);
        chk("irq dropped", 32'h0, {31'h0, irq});
        ev(3'b010);
        rdc("decrypt flag", txrs_pkg::RX_MAC_STATUS_ADDR, 32'h04);
        apb(1'b1, txrs_pkg::RX_MAC_STATUS_ADDR, 32'h04);
        rdc("decrypt read-only", txrs_pkg::RX_MAC_STATUS_ADDR, 32'h04);
        ev(3'b001);
        rdc("decrypt ok", txrs_pkg::RX_MAC_STATUS_ADDR, 32'h0);
        $display("test events done");
        apb(1'b1, txrs_pkg::MONITOR_CONFIG_ADDR, 32'h1A);
        // the write lands at the access edge; look one edge later
        @(posedge pclk);
        chk("threshold", 32'hA, {28'h0, battery_threshold});
        chk("monitor on", 32'h1, {31'h0, battery_monitor_enable});
        supply_below_threshold <= 1'b1;
        repeat (4) @(posedge pclk);
        rdc("battery low", txrs_pkg::RX_MAC_STATUS_ADDR, 32'h20);
        supply_below_threshold <= 1'b0;
        repeat (4) @(posedge pclk);
        rdc("battery ok", txrs_pkg::RX_MAC_STATUS_ADDR, 32'h0);
        $display("test battery done");
        apb(1'b1, txrs_pkg::IRQ_STATUS_ADDR, 32'hF);
        txrun(1'b1);
        rdc("gap done status", txrs_pkg::IRQ_STATUS_ADDR, 32'h8);
        apb(1'b1, txrs_pkg::SECURITY_CONTROL_ONE_ADDR, 32'h1);
        txrun(1'b0);
        rdc("tx idle state", txrs_pkg::TX_STATUS_ADDR, 32'h0);
        $display("test transmit done");
        print_verdict();
    end
endmodule : test_tx_timing_rx_security_status
